// ### accumulator_load_transfers_tb.sv
// testbench for the load transfer decoder
// drives alt_core directly, no partner model
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, a, b); end end
module accumulator_load_transfers_tb;
  import alt_pkg::*;
  logic                 clk_sys, reset, insn_valid, carry_q, skip_q, done_q;
  logic [9:0]           insn;
  logic [5:0]           data_pointer;
  logic [3:0]           acc_q, x_q, xe;
  alt_pkg::alt_src_t    src;
  alt_pkg::alt_ram_wr_t ram_wr;
  int                   bad_count, checks;
  alt_core alt_core_inst (.clk_sys(clk_sys), .reset(reset),
    .insn_valid(insn_valid), .insn(insn), .src(src),
    .data_pointer(data_pointer), .ram_wr(ram_wr), .acc_q(acc_q),
    .x_q(x_q), .carry_q(carry_q), .skip_q(skip_q), .done_q(done_q));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ----
  // one insn, judged after the taking edge has settled
  // ----
  task automatic step(input logic [9:0] op, input logic dn);
    @(posedge clk_sys);
    insn_valid <= 1'b1;
    insn       <= op;
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    #1;
    `CHK(done_q, dn)
    `CHK({carry_q, skip_q}, 2'h0)
  endtask
  task automatic t_regs;
    src <= '{4'hA, 8'hFE, 4'hE, 3'h7};
    step(OPC_WAKEUP2, 1'b1);
    `CHK(acc_q, 4'hA)
    step(OPC_ADC_LOW, 1'b1);
    `CHK(acc_q, 4'h8)
    step(OPC_CLK_CTRL, 1'b1);
    `CHK(acc_q, 4'hE)
    step(OPC_ADC_CTRL, 1'b1);
    `CHK(acc_q, 4'h7)
    step(10'h3FF, 1'b0);
    `CHK(acc_q, 4'h7)
  endtask
  task automatic t_mem;
    for (int j = 0; j < 16; j++) begin
      @(posedge clk_sys);
      ram_wr <= '{1'b1, 6'(j + 32), 4'(15 - j)};
    end
    @(posedge clk_sys);
    ram_wr <= '0;
    xe = X_RST;
    for (int j = 0; j < 16; j++) begin
      // pointer stands one edge ahead of the taking edge
      @(posedge clk_sys);
      data_pointer <= 6'(j + 32);
      xe = xe ^ 4'(j);
      step({OPC_MEM_PFX, 4'(j)}, 1'b1);
      `CHK(x_q, xe)
      `CHK(acc_q, 4'(15 - j))
    end
  endtask
  task automatic summarize;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #20us;
    bad_count++;
    summarize;
  end
  initial begin
    reset <= 1'b1;
    {insn_valid, insn, data_pointer, src, ram_wr} <= '0;
    bad_count = 0;
    checks = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs;
    t_mem;
    summarize;
  end
endmodule

// ### alt_core.sv
// decoder/executor for the accumulator load transfer instructions
// assumes instructions and sources are synchronous to clk_sys
// assumes the data pointer stands one edge before a memory load
`timescale 1ns/1ps
module alt_core
  import alt_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 insn_valid,
  input  wire logic [9:0]           insn,
  input  wire alt_pkg::alt_src_t    src,
  input  wire logic [5:0]           data_pointer,
  input  wire alt_pkg::alt_ram_wr_t ram_wr,
  output logic [3:0]                acc_q,
  output logic [3:0]                x_q,
  output logic                      carry_q,
  output logic                      skip_q,
  output logic                      done_q
);

  import alt_pkg::*;

  // ----------------------------------------------------------------
  // field helpers
  // ----------------------------------------------------------------
  // immediate nibble of a memory load word
  function automatic logic [3:0] imm_field(input logic [9:0] w);
    return w[MEM_PFX_LSB-1:0];
  endfunction

  // opcode prefix of a memory load word
  function automatic logic [5:0] pfx_field(input logic [9:0] w);
    return w[INSN_W-1:MEM_PFX_LSB];
  endfunction

  // prefix match only; the low nibble is free
  function automatic logic is_mem_load(input logic [9:0] w);
    return pfx_field(w) == OPC_MEM_PFX;
  endfunction

  // adc low bits go to the top half, bottom half cleared
  function automatic logic [3:0] adc_low_value(input logic [7:0] res);
    return {res[1:0], 2'h0};
  endfunction

  // bit 3 reads as zero, the control register has three bits
  function automatic logic [3:0] adc_ctrl_value(input logic [2:0] ctl);
    return {1'h0, ctl};
  endfunction

  // x takes its exclusive-or with the immediate
  function automatic logic [3:0] x_update(input logic [3:0] x,
                                           input logic [9:0] w);
    return x ^ imm_field(w);
  endfunction

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // exact words first; the memory prefix only when none of them matched
  function automatic alt_op_t decode(input logic [9:0] w);
    alt_op_t op;
    op = ALT_OP_NONE;
    case (w)
      OPC_WAKEUP2:  op = ALT_OP_WAKE2;
      OPC_ADC_LOW:  op = ALT_OP_ADCLO;
      OPC_CLK_CTRL: op = ALT_OP_CLK;
      OPC_ADC_CTRL: op = ALT_OP_ADCCTL;
      default: begin
        if (is_mem_load(w)) begin
          op = ALT_OP_MEM;
        end
      end
    endcase
    return op;
  endfunction

  // every recognised word writes the accumulator
  function automatic logic is_taken(input alt_op_t op);
    return op != ALT_OP_NONE;
  endfunction

  // only the memory load touches x
  function automatic logic writes_x(input alt_op_t op);
    return op == ALT_OP_MEM;
  endfunction

  // ----------------------------------------------------------------
  // working signals
  // ----------------------------------------------------------------
  alt_op_t    op_d;
  logic       take_d;
  logic       x_we_d;
  logic [3:0] reg_val_d;
  logic [3:0] acc_d;
  logic [3:0] x_d;
  logic [3:0] mem_rdata;

  always_comb begin
    op_d = ALT_OP_NONE;
    if (insn_valid) begin
      op_d = decode(insn);
    end
  end

  always_comb begin
    take_d = is_taken(op_d);
    x_we_d = writes_x(op_d);
  end

  // ----------------------------------------------------------------
  // data memory
  // ----------------------------------------------------------------
  // the read register follows the live pointer every edge, so a load
  // needs the pointer to have stood one edge before it is taken; this
  // keeps the load to one cycle without a read path through the array
  alt_ram alt_ram_inst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr      (ram_wr),
    .raddr   (data_pointer),
    .rdata_q (mem_rdata)
  );

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  // register sources only; memory data join below
  always_comb begin
    reg_val_d = acc_q;
    case (op_d)
      ALT_OP_WAKE2: begin
        reg_val_d = src.wakeup_ctrl2_reg;
      end
      ALT_OP_ADCLO: begin
        reg_val_d = adc_low_value(src.adc_result);
      end
      ALT_OP_CLK: begin
        reg_val_d = src.clock_ctrl_reg;
      end
      ALT_OP_ADCCTL: begin
        reg_val_d = adc_ctrl_value(src.adc_ctrl_reg);
      end
      default: begin
        reg_val_d = acc_q;
      end
    endcase
  end

  always_comb begin
    acc_d = reg_val_d;
    if (op_d == ALT_OP_MEM) begin
      acc_d = mem_rdata;
    end
  end

  always_comb begin
    x_d = x_q;
    if (x_we_d) begin
      x_d = x_update(x_q, insn);
    end
  end

  // ----------------------------------------------------------------
  // architectural registers
  // ----------------------------------------------------------------
  // written at the taking edge, so the next word already sees them
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_q <= ACC_RST;
    end else if (take_d) begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      x_q <= X_RST;
    end else if (x_we_d) begin
      x_q <= x_d;
    end
  end

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  // carry belongs to the rest of the core; this group only holds it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      carry_q <= 1'h0;
    end else begin
      carry_q <= carry_q;
    end
  end

  // no word of this group ever skips
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      skip_q <= 1'h0;
    end else begin
      skip_q <= 1'h0;
    end
  end

  // one-cycle pulse per recognised word; ignored words leave no trace
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      done_q <= 1'h0;
    end else begin
      done_q <= take_d;
    end
  end

endmodule

// ### alt_core_checker.sv
// checker for the load transfer decoder
// bound to alt_core, sees its ports only
`timescale 1ns/1ps
module alt_core_checker
  import alt_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              insn_valid,
  input wire logic [9:0]        insn,
  input wire alt_pkg::alt_src_t src,
  input wire logic [3:0]        acc_q,
  input wire logic [3:0]        x_q,
  input wire logic              carry_q,
  input wire logic              skip_q,
  input wire logic              done_q
);
  // ----
  // properties
  // ----
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  // masked word: zero is no opcode, so valid is implied
  wire [9:0] i = insn & {10{insn_valid}};
  property p_wk; i == OPC_WAKEUP2 |=>
    acc_q == $past(src.wakeup_ctrl2_reg); endproperty
  a_wk: assert property (p_wk) else $error("wake load");
  property p_lo; i == OPC_ADC_LOW |=>
    acc_q == {$past(src.adc_result[1:0]), 2'h0}; endproperty
  a_lo: assert property (p_lo) else $error("adc low");
  property p_cl; i == OPC_CLK_CTRL |=>
    acc_q == $past(src.clock_ctrl_reg); endproperty
  a_cl: assert property (p_cl) else $error("clk load");
  property p_ac; i == OPC_ADC_CTRL |=>
    acc_q == {1'b0, $past(src.adc_ctrl_reg)}; endproperty
  a_ac: assert property (p_ac) else $error("adc ctrl");
  property p_x; i[9:4] == OPC_MEM_PFX |=>
    x_q == ($past(x_q) ^ $past(i[3:0])); endproperty
  a_x: assert property (p_x) else $error("x xor");
  property p_xs; i[9:4] != OPC_MEM_PFX |=> $stable(x_q); endproperty
  a_xs: assert property (p_xs) else $error("x moved");
  property p_cy; 1'b1 |=> $stable(carry_q) && !skip_q; endproperty
  a_cy: assert property (p_cy) else $error("carry or skip");
  property p_dn; !insn_valid |=> !done_q; endproperty
  a_dn: assert property (p_dn) else $error("done");
endmodule

bind alt_core alt_core_checker alt_core_checker_inst (.clk_sys(clk_sys),
  .reset(reset), .insn_valid(insn_valid), .insn(insn), .src(src),
  .acc_q(acc_q), .x_q(x_q), .carry_q(carry_q), .skip_q(skip_q),
  .done_q(done_q));

// ### alt_pkg.sv
// package for the accumulator load transfer decoder
// assumes a 10-bit instruction word and a 4-bit data path
package alt_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int INSN_W = 10;
  localparam int NIB_W  = 4;
  localparam int DP_W   = 6;
  localparam int RAM_DEPTH = 64;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [9:0] OPC_WAKEUP2   = 10'h25A;
  localparam logic [9:0] OPC_ADC_LOW   = 10'h249;
  localparam logic [9:0] OPC_CLK_CTRL  = 10'h252;
  localparam logic [5:0] OPC_MEM_PFX   = 6'h2C;
  localparam logic [9:0] OPC_ADC_CTRL  = 10'h24C;
  localparam int         MEM_PFX_LSB   = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] X_RST   = 4'h0;

  typedef enum logic [2:0] {
    ALT_OP_NONE   = 3'h0,
    ALT_OP_WAKE2  = 3'h1,
    ALT_OP_ADCLO  = 3'h3,
    ALT_OP_MEM    = 3'h2,
    ALT_OP_CLK    = 3'h6,
    ALT_OP_ADCCTL = 3'h7
  } alt_op_t;

  typedef struct packed {
    logic [3:0] wakeup_ctrl2_reg;
    logic [7:0] adc_result;
    logic [3:0] clock_ctrl_reg;
    logic [2:0] adc_ctrl_reg;
  } alt_src_t;

  typedef struct packed {
    logic       we;
    logic [5:0] addr;
    logic [3:0] wdata;
  } alt_ram_wr_t;

endpackage

// ### alt_ram.sv
// little data memory of nibbles, one write port, registered read
// assumes single clock, synchronous active high reset
`timescale 1ns/1ps
module alt_ram
  import alt_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire alt_pkg::alt_ram_wr_t wr,
  input  wire logic [5:0]           raddr,
  output logic [3:0]                rdata_q
);

  logic [3:0] mem [RAM_DEPTH];

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (wr.we) begin
      mem[wr.addr] <= wr.wdata;
    end
  end

  // read data registered; write-through not provided
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata_q <= 4'h0;
    end else begin
      rdata_q <= mem[raddr];
    end
  end

endmodule
